// ---- design/dma_status_pkg.sv ----
// Package with register map, field positions, reset values and carrier types of the DMA queue and status block.
// Notes on behaviour
// R1 - Buffers exhausted mid-frame: stop, corrupt FCS, assert tx error, set W1C flag.
// R2 - Set transmit-complete flag after each sent frame; cleared by writing one.
// R3 - Late fetch, bus error or owned descriptor mid-frame sets starve flag, forces bad CRC.
// R4 - Receive pointer loads list start; low bits advance and wrap at 1024 or wrap bit.
// R5 - Reading receive pointer returns descriptor currently accessed.
// R6 - Two-word bursts; software keeps bit 2 of queue start zero.
// R7 - Transmit pointer loads list start; low bits advance and wrap at 1024 or wrap bit.
// R8 - Transmit pointer writes take effect only while transmit-active is low.
// R9 - Reading transmit pointer returns first descriptor of current or next frame.
// R10 - Receive status bits clear by writing one; writes never set bits.
// R11 - Owned receive descriptor sets no-buffer flag each failed attempt; retried per frame.
// R12 - Set frame-received flag when frames are stored; cleared by writing one.
// R13 - Receive store failure sets overflow flag and reclaims the buffer.
// R14 - Management-done interrupt bit set on PHY operation end; clears on read.
// R15 - Receive-complete interrupt bit set per stored frame; clears on read.
// R16 - Owned descriptor fetch sets per-direction interrupt bits; clear on read.
// R17 - Underrun interrupt on fetch failure, owned mid-frame, or transmit pointer write.
// R18 - Transmit-error and transmit-complete interrupt bits; clear on read.
// R19 - Receive overflow interrupt bit set with overflow status flag; clears on read.
// R20 - Bus-error interrupt bit set on any DMA error response; clears on read.
// R21 - Pause-received and pause-expired interrupt bits; clear on read.
// R22 - Shared interrupt bit positions 0-7 and 10-13 in status and enable.
// R23 - Transmit-active status bit reads high while transmitting.
// R24 - Writing one to an enable bit enables that interrupt source.
// R25 - Interrupt output high when any status bit is set and enabled.
package dma_status_pkg;
	// Word byte addresses of the registers.
	localparam logic [7:0] tx_status_off = 8'h14;
	localparam logic [7:0] rx_queue_off = 8'h18;
	localparam logic [7:0] tx_queue_off = 8'h1c;
	localparam logic [7:0] rx_status_off = 8'h20;
	localparam logic [7:0] irq_status_off = 8'h24;
	localparam logic [7:0] irq_enable_off = 8'h28;
	localparam logic [7:0] irq_mask_off = 8'h30;
	// Transmit status field positions.
	localparam int tx_owned_pos = 0;
	localparam int tx_retry_pos = 2;
	localparam int tx_active_pos = 3;
	localparam int tx_exhaust_pos = 4;
	localparam int tx_done_pos = 5;
	localparam int tx_starve_pos = 6;
	// Receive status field positions.
	localparam int rx_nobuf_pos = 0;
	localparam int rx_stored_pos = 1;
	localparam int rx_ovf_pos = 2;
	// Interrupt bit positions shared by status and enable.
	localparam int mgmt_done_pos = 0;
	localparam int rx_done_pos = 1;
	localparam int rx_owned_pos = 2;
	localparam int tx_owned_irq_pos = 3;
	localparam int tx_starve_irq_pos = 4;
	localparam int retry_limit_pos = 5;
	localparam int tx_exhaust_irq_pos = 6;
	localparam int tx_done_irq_pos = 7;
	localparam int rx_ovf_irq_pos = 10;
	localparam int bus_err_pos = 11;
	localparam int pause_rx_pos = 12;
	localparam int pause_expired_pos = 13;
	localparam logic [13:0] irq_impl_mask = 14'h3cff;
	// Queue pointer layout: word aligned, 1024 descriptors of two words.
	localparam int queue_low_bits = 13;
	localparam logic [31:0] queue_reset = 32'h0000_0000;
	localparam logic [31:0] unmapped_read = 32'h0000_0000;
	// Transmit side events from the DMA and MAC engines.
	typedef struct packed {
		logic frame_start;
		logic frame_end;
		logic buf_used;
		logic buf_wrap;
		logic owned_first;
		logic owned_mid;
		logic late_fetch;
		logic bus_err;
		logic retry_limit;
	} tx_events_t;
	// Receive side events from the DMA and MAC engines.
	typedef struct packed {
		logic buf_used;
		logic buf_wrap;
		logic owned_fetch;
		logic frame_stored;
		logic late_store;
		logic bus_err;
		logic pause_rx;
		logic pause_zero;
	} rx_events_t;
	// Transmit line controls toward the MAC.
	typedef struct packed {
		logic halt;
		logic bad_fcs;
		logic tx_err;
	} tx_ctrl_t;
endpackage

// ---- design/dma_queue_status.sv ----
// DMA descriptor queue pointers, transmit and receive status and interrupt status logic.
`timescale 1ns/1ps
`default_nettype none
module dma_queue_status (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire dma_status_pkg::tx_events_t tx_ev,
	input wire dma_status_pkg::rx_events_t rx_ev,
	input wire logic mgmt_done,
	input wire logic tx_start,
	output dma_status_pkg::tx_ctrl_t tx_ctrl,
	output logic tx_active,
	output logic [31:0] rx_desc_addr,
	output logic [31:0] tx_desc_addr,
	output logic irq
);
	import dma_status_pkg::*;

	logic [31:0] rx_base_r;
	logic [31:0] rx_ptr_r;
	logic [31:0] tx_base_r;
	logic [31:0] tx_ptr_r;
	logic [31:0] tx_frame_r;
	logic [6:0] tx_status_r;
	logic [2:0] rx_status_r;
	logic [13:0] irq_status_r;
	logic [13:0] irq_enable_r;
	logic tx_active_r;
	logic in_frame_r;
	logic ack_r;
	logic waitreq_r;
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;
	logic wr_hit;
	logic rd_hit;
	logic tx_exhaust;
	logic tx_starve;
	logic rx_ovf;
	logic tx_ptr_wr;
	logic [13:0] irq_set;
	logic [31:0] wmask;

	// Every access answers one cycle after it starts. A write lands at the accept edge only, while a read
	// latches its data in the first cycle so that the data stand at the accept edge.
	assign wr_hit = avs_write && ack_r;
	assign rd_hit = avs_read && !ack_r;
	assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}}, {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

	// Event decode shared by status flags and interrupt bits.
	// An owned descriptor met while a frame is on the line means the buffers ran out mid-frame.
	assign tx_exhaust = in_frame_r && tx_ev.owned_mid; // R1
	assign tx_starve = tx_ev.late_fetch || tx_ev.bus_err || tx_ev.owned_mid; // R3
	assign rx_ovf = rx_ev.late_store || rx_ev.bus_err; // R13
	assign tx_ptr_wr = wr_hit && (avs_address == tx_queue_off) && !tx_active_r; // R8

	// Sources collected into interrupt bit positions.
	always_comb begin
		irq_set = '0;
		irq_set[mgmt_done_pos] = mgmt_done; // R14
		irq_set[rx_done_pos] = rx_ev.frame_stored; // R15
		irq_set[rx_owned_pos] = rx_ev.owned_fetch; // R16
		irq_set[tx_owned_irq_pos] = tx_ev.owned_first || tx_ev.owned_mid; // R16
		irq_set[tx_starve_irq_pos] = tx_starve || (wr_hit && avs_address == tx_queue_off); // R17
		irq_set[retry_limit_pos] = tx_ev.retry_limit;
		irq_set[tx_exhaust_irq_pos] = tx_exhaust; // R18
		irq_set[tx_done_irq_pos] = tx_ev.frame_end; // R18
		irq_set[rx_ovf_irq_pos] = rx_ovf; // R19
		irq_set[bus_err_pos] = tx_ev.bus_err || rx_ev.bus_err; // R20
		irq_set[pause_rx_pos] = rx_ev.pause_rx; // R21
		irq_set[pause_expired_pos] = rx_ev.pause_zero; // R21
	end

	// Bus handshake: waitrequest high on the first cycle, low on the second.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ack_r <= 1'b0;
			waitreq_r <= 1'b1;
		end else begin
			ack_r <= (avs_read || avs_write) && !ack_r;
			waitreq_r <= !((avs_read || avs_write) && !ack_r);
		end
	end
	// Waitrequest comes from its own flop so the bus sees no combinational path through the block.
	assign avs_waitrequest = waitreq_r;

	// Read data registered at the request's first cycle so it stands at the accept edge.
	always_comb begin
		unique case (avs_address)
			tx_status_off: begin
				rdata_nxt = {25'h0, tx_status_r};
				rdata_nxt[tx_active_pos] = tx_active_r; // R23
			end
			rx_queue_off: rdata_nxt = rx_ptr_r; // R5
			tx_queue_off: rdata_nxt = tx_frame_r; // R9
			rx_status_off: rdata_nxt = {29'h0, rx_status_r};
			irq_status_off: rdata_nxt = {18'h0, irq_status_r};
			irq_mask_off: rdata_nxt = {18'h0, ~irq_enable_r & irq_impl_mask};
			default: rdata_nxt = unmapped_read;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rdata_r <= '0;
		end else if (rd_hit) begin
			rdata_r <= rdata_nxt;
		end
	end
	assign avs_readdata = rdata_r;

	// Transmit activity: set by a start request, cleared when a frame's first descriptor is found owned or on a fault.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_active_r <= 1'b0;
			in_frame_r <= 1'b0;
		end else begin
			if (tx_start) begin
				tx_active_r <= 1'b1; // R23
			end else if (tx_ev.owned_first || tx_ev.owned_mid || tx_starve) begin
				tx_active_r <= 1'b0;
			end
			if (tx_ev.frame_start) begin
				in_frame_r <= 1'b1;
			end else if (tx_ev.frame_end || tx_ev.owned_mid || tx_starve) begin
				in_frame_r <= 1'b0;
			end
		end
	end

	// Transmit line controls: bad FCS on exhaustion or starvation, halt on exhaustion or on starvation in a frame.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_ctrl <= '0;
		end else begin
			tx_ctrl.halt <= tx_exhaust || (in_frame_r && tx_starve); // R1
			tx_ctrl.bad_fcs <= tx_exhaust || tx_starve; // R1 R3
			tx_ctrl.tx_err <= tx_exhaust; // R1
		end
	end

	// Transmit status flags: hardware set wins over a write-one clear.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_status_r <= '0;
		end else begin
			if (wr_hit && avs_address == tx_status_off) begin
				tx_status_r <= tx_status_r & ~(avs_writedata[6:0] & wmask[6:0]);
			end
			if (tx_ev.owned_first) tx_status_r[tx_owned_pos] <= 1'b1;
			if (tx_ev.retry_limit) tx_status_r[tx_retry_pos] <= 1'b1;
			if (tx_exhaust) tx_status_r[tx_exhaust_pos] <= 1'b1; // R1
			if (tx_ev.frame_end) tx_status_r[tx_done_pos] <= 1'b1; // R2
			if (tx_starve) tx_status_r[tx_starve_pos] <= 1'b1; // R3
			tx_status_r[tx_active_pos] <= 1'b0;
		end
	end
	assign tx_active = tx_active_r;

	// Receive status flags: write one clears, writes never set.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_status_r <= '0;
		end else begin
			if (wr_hit && avs_address == rx_status_off) begin
				rx_status_r <= rx_status_r & ~(avs_writedata[2:0] & wmask[2:0]); // R10
			end
			if (rx_ev.owned_fetch) rx_status_r[rx_nobuf_pos] <= 1'b1; // R11
			if (rx_ev.frame_stored) rx_status_r[rx_stored_pos] <= 1'b1; // R12
			if (rx_ovf) rx_status_r[rx_ovf_pos] <= 1'b1; // R13
		end
	end

	// Receive queue pointer: load, advance per buffer, wrap in the low bits.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_base_r <= queue_reset;
			rx_ptr_r <= queue_reset;
		end else if (wr_hit && avs_address == rx_queue_off) begin
			rx_base_r <= {avs_writedata[31:2], 2'b00}; // R4 R6
			rx_ptr_r <= {avs_writedata[31:2], 2'b00};
		end else if (rx_ev.buf_used && !rx_ovf) begin
			if (rx_ev.buf_wrap) begin
				rx_ptr_r <= rx_base_r; // R4
			end else begin
				rx_ptr_r[queue_low_bits-1:0] <= rx_ptr_r[queue_low_bits-1:0] + 13'h8; // R4
			end
		end else if (rx_ovf) begin
			rx_ptr_r <= rx_ptr_r; // R13
		end
	end

	// Transmit queue pointer: loads only while idle, tracks the frame's first descriptor.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			tx_base_r <= queue_reset;
			tx_ptr_r <= queue_reset;
			tx_frame_r <= queue_reset;
		end else if (tx_ptr_wr) begin
			tx_base_r <= {avs_writedata[31:2], 2'b00}; // R7 R8
			tx_ptr_r <= {avs_writedata[31:2], 2'b00};
			tx_frame_r <= {avs_writedata[31:2], 2'b00};
		end else begin
			if (tx_ev.buf_used) begin
				if (tx_ev.buf_wrap) begin
					tx_ptr_r <= tx_base_r; // R7
				end else begin
					tx_ptr_r[queue_low_bits-1:0] <= tx_ptr_r[queue_low_bits-1:0] + 13'h8; // R7
				end
			end
			if (tx_ev.frame_end) begin
				tx_frame_r <= tx_ev.buf_used ? (tx_ev.buf_wrap ? tx_base_r :
					{tx_ptr_r[31:queue_low_bits], tx_ptr_r[queue_low_bits-1:0] + 13'h8}) : tx_ptr_r; // R9
			end
		end
	end

	// Descriptor addresses toward the DMA engine.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			rx_desc_addr <= queue_reset;
			tx_desc_addr <= queue_reset;
		end else begin
			rx_desc_addr <= rx_ptr_r;
			tx_desc_addr <= tx_ptr_r;
		end
	end

	// Interrupt status: set wins over clear on read; only implemented bits exist.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_status_r <= '0;
		end else if (rd_hit && avs_address == irq_status_off) begin
			irq_status_r <= irq_set & irq_impl_mask; // R14 R15 R16 R17 R18 R19 R20 R21
		end else begin
			irq_status_r <= irq_status_r | (irq_set & irq_impl_mask); // R22
		end
	end

	// Interrupt enable: write one sets an enable bit.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq_enable_r <= '0;
		end else if (wr_hit && avs_address == irq_enable_off) begin
			irq_enable_r <= irq_enable_r | (avs_writedata[13:0] & wmask[13:0] & irq_impl_mask); // R24
		end
	end

	// Single interrupt output.
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_r & irq_enable_r); // R25
		end
	end
endmodule // dma_queue_status
`default_nettype wire

// ---- testbench/dma_queue_status_sva.sv ----
// Checker of bus, transmit fault, pointer and interrupt behaviour at the block's ports.
`timescale 1ns/1ps
`default_nettype none
module dma_queue_status_sva (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire dma_status_pkg::tx_events_t tx_ev,
	input wire dma_status_pkg::rx_events_t rx_ev,
	input wire logic mgmt_done,
	input wire logic tx_start,
	input wire dma_status_pkg::tx_ctrl_t tx_ctrl,
	input wire logic tx_active,
	input wire logic [31:0] rx_desc_addr,
	input wire logic [31:0] tx_desc_addr,
	input wire logic irq
);
	import dma_status_pkg::*;
	logic isr_rd, rxq_wr, txq_wr;
	// Accepted register accesses that the properties key on.
	assign isr_rd = avs_read && !avs_waitrequest && avs_address == irq_status_off;
	assign rxq_wr = avs_write && !avs_waitrequest && avs_address == rx_queue_off && avs_writedata[2:0] == 3'h0;
	assign txq_wr = avs_write && !avs_waitrequest && avs_address == tx_queue_off;
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	property p_starve_fcs; tx_ev.late_fetch || tx_ev.bus_err |=> tx_ctrl.bad_fcs; endproperty
	a_starve_fcs: assert property (p_starve_fcs) else $error("bad FCS missing after fetch failure");
	property p_err_cause; $rose(tx_ctrl.tx_err) |-> $past(tx_ev.owned_mid); endproperty
	a_err_cause: assert property (p_err_cause) else $error("transmit error without exhaustion");
	property p_err_halt; tx_ctrl.tx_err |-> tx_ctrl.halt && tx_ctrl.bad_fcs; endproperty
	a_err_halt: assert property (p_err_halt) else $error("transmit error without halt and bad FCS");
	property p_active_cause; $rose(tx_active) |-> $past(tx_start); endproperty
	a_active_cause: assert property (p_active_cause) else $error("transmit active without start");
	property p_irq_fall; $fell(irq) |-> $past(isr_rd) || $past(isr_rd, 2) || $past(isr_rd, 3); endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("interrupt dropped without status read");
	property p_rxq_load; rxq_wr && !rx_ev.buf_used ##1 !rx_ev.buf_used |=> rx_desc_addr == $past(avs_writedata, 2);
	endproperty
	a_rxq_load: assert property (p_rxq_load) else $error("receive pointer not loaded");
	property p_txq_lock; txq_wr && tx_active && avs_writedata != tx_desc_addr && !tx_ev.buf_used
		|=> ##1 tx_desc_addr != $past(avs_writedata, 2); endproperty
	a_txq_lock: assert property (p_txq_lock) else $error("transmit pointer written while active");
	property p_isr_bits; isr_rd |-> avs_readdata[31:14] == 18'h0 && avs_readdata[9:8] == 2'h0; endproperty
	a_isr_bits: assert property (p_isr_bits) else $error("interrupt status beyond defined bits");
	c_isr_set: cover property (isr_rd && avs_readdata != 32'h0);
	c_tx_err: cover property (tx_ctrl.tx_err);
	c_txq_lock: cover property (txq_wr && tx_active);
endmodule // dma_queue_status_sva
`default_nettype wire

// ---- testbench/dma_event_source.sv ----
// Model of the DMA and MAC engines that raise one-cycle event pulses toward the block.
`timescale 1ns/1ps
`default_nettype none
module dma_event_source (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [18:0] req,
	output dma_status_pkg::tx_events_t tx_ev,
	output dma_status_pkg::rx_events_t rx_ev,
	output logic mgmt_done,
	output logic tx_start
);
	import dma_status_pkg::*;
	// Each request bit becomes a single-cycle pulse on its event line.
	always_ff @(posedge core_clk) begin
		{tx_start, mgmt_done, rx_ev, tx_ev} <= rst ? 19'h0 : req;
	end
endmodule // dma_event_source
`default_nettype wire

// ---- testbench/testbench.sv ----
// Self-checking bench of the DMA queue, status and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import dma_status_pkg::*;
	logic core_clk, rst, avs_read, avs_write, avs_waitrequest, mgmt_done, tx_start, tx_active, irq;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rx_desc_addr, tx_desc_addr, base, r;
	logic [3:0] avs_byteenable;
	logic [18:0] req;
	tx_events_t tx_ev;
	rx_events_t rx_ev;
	tx_ctrl_t tx_ctrl;
	logic [31:0] expq[$];
	int errors, comparisons;
	// Single event pulses and the interrupt bits each one sets.
	logic [18:0] ev_tab[11] = '{19'h20000, 19'h02000, 19'h04000, 19'h00010, 19'h00004, 19'h00001,
		19'h00080, 19'h01000, 19'h00002, 19'h00400, 19'h00200};
	logic [13:0] irq_tab[11] = '{14'h0001, 14'h0002, 14'h0004, 14'h0008, 14'h0010, 14'h0020,
		14'h0080, 14'h0400, 14'h0810, 14'h1000, 14'h2000};
	dma_queue_status dut (.*);
	dma_event_source model (.*);
	// Free-running core clock.
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One bus cycle, held until waitrequest is seen low.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic ev(input logic [18:0] v);
		@(posedge core_clk);
		req <= v;
		@(posedge core_clk);
		req <= 19'h0;
	endtask
	task automatic wrap_up();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Read data are matched, oldest note first, at the accept edge.
	always @(posedge core_clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			chk(avs_readdata, expq.pop_front(), "readdata");
		end
	end
	// Watchdog against a hung handshake.
	initial begin
		repeat (20000) @(posedge core_clk);
		errors++;
		wrap_up();
	end
	initial begin
		rst = 1'b1;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hf;
		req = 19'h0;
		errors = 0;
		comparisons = 0;
		r = $urandom(32'h9856);
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		rd(rx_queue_off, queue_reset);
		rd(tx_queue_off, queue_reset);
		rd(rx_status_off, 32'h0);
		rd(irq_enable_off, 32'h0);
		rd(8'h3c, unmapped_read);
		// Receive list: a full lap of 1024 descriptors, then a wrap bit, then an overflow.
		base = $urandom() & 32'hffff_e000;
		bus(1'b1, rx_queue_off, base);
		rd(rx_queue_off, base);
		repeat (1023) ev(19'h10000);
		rd(rx_queue_off, base + 32'h1ff8);
		ev(19'h10000);
		rd(rx_queue_off, base);
		repeat (2) ev(19'h10000);
		ev(19'h18000);
		rd(rx_queue_off, base);
		ev(19'h11000);
		rd(rx_queue_off, base);
		ev(19'h04000);
		ev(19'h04000);
		ev(19'h02000);
		rd(rx_status_off, 32'h7);
		bus(1'b1, rx_status_off, 32'h2);
		rd(rx_status_off, 32'h5);
		bus(1'b1, rx_status_off, 32'h0);
		rd(rx_status_off, 32'h5);
		bus(1'b1, rx_status_off, 32'h7);
		rd(rx_status_off, 32'h0);
		rd(irq_status_off, 32'h406);
		rd(irq_status_off, 32'h0);
		// Transmit pointer load, a refused reload in mid-frame, then exhaustion in the frame.
		base = $urandom() & 32'hffff_fff8;
		bus(1'b1, tx_queue_off, base);
		rd(tx_queue_off, base);
		rd(irq_status_off, 32'h10);
		ev(19'h40100);
		repeat (2) @(posedge core_clk);
		chk({31'h0, tx_active}, 32'h1, "tx_active");
		rd(tx_status_off, 32'h8);
		bus(1'b1, tx_queue_off, base ^ 32'h0010_0000);
		rd(tx_queue_off, base);
		ev(19'h00008);
		repeat (2) @(posedge core_clk);
		chk({29'h0, tx_ctrl}, 32'h7, "tx_ctrl");
		rd(tx_status_off, 32'h50);
		rd(irq_status_off, 32'h58);
		bus(1'b1, tx_status_off, 32'h50);
		rd(tx_status_off, 32'h0);
		// Eleven sources, all but exhaustion, each alone set their own bits, and one read clears them.
		for (int i = 0; i < 11; i++) begin
			ev(ev_tab[i]);
			rd(irq_status_off, {18'h0, irq_tab[i]});
			rd(irq_status_off, 32'h0);
		end
		rd(tx_status_off, 32'h65);
		rd(rx_status_off, 32'h7);
		// Only an enabled source drives the interrupt line.
		bus(1'b1, irq_enable_off, 32'h1);
		rd(irq_mask_off, 32'h3cfe);
		ev(19'h00400);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0, "irq");
		rd(irq_status_off, 32'h1000);
		ev(19'h20000);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h1, "irq");
		rd(irq_status_off, 32'h1);
		repeat (3) @(posedge core_clk);
		chk({31'h0, irq}, 32'h0, "irq");
		wrap_up();
	end
endmodule // testbench
bind dma_queue_status dma_queue_status_sva sva_i (.*);
`default_nettype wire
